//--- spct_ctrl.sv
// serial peripheral controller: control register, timing gaps, master and slave engine
// assumes AXI4-Lite master on core_clk; serial pins are asynchronous to core_clk
// Functional notes
// RULE1: role-select bit 18 zero makes master, one makes slave.
// RULE2: interrupt enable bit 17 gates completion interrupt to the CPU.
// RULE3: completion flag 16 reads zero while busy, sets at transfer end; in slave mode it is not cleared at start and sets at each word end.
// RULE4: writing one clears the completion flag; writing zero leaves it.
// RULE5: gap field 15:12 inserts idle between transactions, master only.
// RULE6: gap spans trailing clock edge to next leading edge per polarity.
// RULE7: gap field resets to zero.
// RULE8: transaction count zero means gap field only affects byte gaps.
// RULE9: per-byte gap bit 19 acts only for 32-bit word width.
// RULE10: per-byte gap lasts gap field plus two serial clock cycles.
// RULE11: byte reorder sends and receives least significant byte first; the code reorders 32-bit words only.
// RULE12: transaction gap lasts gap field plus two serial clock cycles.
`timescale 1ns/100ps
module spct_ctrl (
   input  wire logic                       core_clk,
   input  wire logic                       rst_n,
   input  wire logic [spct_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                       awvalid,
   output logic                            awready,
   input  wire logic [spct_pkg::DATA_W-1:0] wdata,
   input  wire logic [3:0]                 wstrb,
   input  wire logic                       wvalid,
   output logic                            wready,
   output logic [1:0]                      bresp,
   output logic                            bvalid,
   input  wire logic                       bready,
   input  wire logic [spct_pkg::ADDR_W-1:0] araddr,
   input  wire logic                       arvalid,
   output logic                            arready,
   output logic [spct_pkg::DATA_W-1:0]     rdata,
   output logic [1:0]                      rresp,
   output logic                            rvalid,
   input  wire logic                       rready,
   input  wire logic                       sclkIn,
   output logic                            sclkOut,
   output logic                            sclkOe,
   input  wire logic                       selNIn,
   output logic                            selNOut,
   output logic                            selNOe,
   input  wire logic                       mosiIn,
   output logic                            mosiOut,
   output logic                            mosiOe,
   input  wire logic                       misoIn,
   output logic                            misoOut,
   output logic                            misoOe,
   output logic                            irq
);
   import spct_pkg::*;

   typedef struct packed {
      logic                reorder;
      logic                perByteGapEnable;
      logic                slave;
      logic                doneIrqEnable;
      logic                doneIrqFlag;
      logic [3:0]          transactionGapLength;
      logic [1:0]          transactionCount;
      logic [1:0]          wordWidthSelect;
      logic                serialClockPolarity;
      logic                irqMask;
      logic [DATA_W-1:0]   txData;
      logic [DATA_W-1:0]   rxData;
      logic [DATA_W-1:0]   shift;
      logic                rxBit;
      logic                phase;
      logic [CNT_W-1:0]    bitCnt;
      logic [1:0]          txnCnt;
      logic [CNT_W-1:0]    gapCnt;
      logic [3:0]          divCnt;
      spct_state_t         state;
      logic                sclk;
      logic                selN;
      logic                sclkS1;
      logic                sclkS2;
      logic                sclkS3;
      logic                selS1;
      logic                selS2;
      logic                mosiS1;
      logic                mosiS2;
      logic                misoS1;
      logic                misoS2;
      logic                awHeld;
      logic [ADDR_W-1:0]   awAddr;
      logic                wHeld;
      logic [DATA_W-1:0]   wData;
      logic [3:0]          wStrb;
      logic                bValid;
      logic [1:0]          bResp;
      logic                rValid;
      logic [DATA_W-1:0]   rData;
      logic [1:0]          rResp;
   } spct_regs_t;

   spct_regs_t q;
   spct_regs_t n;

   function automatic logic [DATA_W-1:0] swapBytes(input logic [DATA_W-1:0] v);
      swapBytes = {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction : swapBytes

   function automatic logic [CNT_W-1:0] widthBits(input logic [1:0] sel);
      case (sel)
         WIDTH_8:  widthBits = BYTE_BITS;
         WIDTH_16: widthBits = BITS_16;
         WIDTH_24: widthBits = BITS_24;
         default:  widthBits = BITS_32;
      endcase
   endfunction : widthBits

   function automatic logic [DATA_W-1:0] laneMask(input logic [3:0] strb);
      laneMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction : laneMask

   logic                wordIs32;
   logic [CNT_W-1:0]    wBits;
   logic [DATA_W-1:0]   wMask;
   logic [DATA_W-1:0]   txWord;
   logic [DATA_W-1:0]   loadWord;
   logic [CNT_W-1:0]    gapHalves;
   logic                tick;
   logic                writeFire;
   logic [DATA_W-1:0]   wEff;
   logic [DATA_W-1:0]   wBitsSet;
   logic                clrDone;
   logic                setDone;
   logic                startGo;
   logic                leadEdge;
   logic                trailEdge;
   logic [DATA_W-1:0]   shNext;
   logic [CNT_W-1:0]    bitNext;
   logic [DATA_W-1:0]   rdWord;
   logic                rdOk;

   always_comb begin
      wordIs32  = (q.wordWidthSelect == WIDTH_32);
      wBits     = widthBits(q.wordWidthSelect);
      wMask     = ~(DATA_W'('1) << wBits);
      if (wordIs32)
         wMask  = '1;
      // byte reorder only meaningful on full words
      txWord    = (q.reorder && wordIs32) ? swapBytes(q.txData) : q.txData; // [RULE11]
      loadWord  = txWord << (CNT_W'(DATA_W) - wBits);
      gapHalves = CNT_W'({2'h0, q.transactionGapLength} + GAP_EXTRA) << 1; // [RULE10] [RULE12]
      tick      = (q.divCnt == HALF_CYC_M1);
      // slave edges seen only on the second and third sync stages
      leadEdge  = (q.sclkS3 == q.serialClockPolarity) && (q.sclkS2 != q.serialClockPolarity);
      trailEdge = (q.sclkS3 != q.serialClockPolarity) && (q.sclkS2 == q.serialClockPolarity);
      shNext    = {q.shift[SH_MSB-1:0], q.rxBit};
      bitNext   = q.bitCnt + CNT_W'(1);
      rdWord    = '0;
      rdOk      = 1'b1;
      case (araddr)
         OFF_CTRL: begin
            rdWord[BIT_GO]                = (q.state != ST_IDLE);
            rdWord[BIT_POL]               = q.serialClockPolarity;
            rdWord[WID_LO+1:WID_LO]       = q.wordWidthSelect;
            rdWord[CNT_LO+1:CNT_LO]       = q.transactionCount;
            rdWord[GAP_LO+3:GAP_LO]       = q.transactionGapLength;
            rdWord[BIT_DONE]              = q.doneIrqFlag;
            rdWord[BIT_IEN]               = q.doneIrqEnable;
            rdWord[BIT_SLAVE]             = q.slave;
            rdWord[BIT_BGAP]              = q.perByteGapEnable;
            rdWord[BIT_REORD]             = q.reorder;
         end
         OFF_TX:   rdWord = q.txData;
         OFF_RX:   rdWord = q.rxData;
         OFF_MASK: rdWord[MASK_BIT] = q.irqMask;
         default:  rdOk = 1'b0;
      endcase

      n = q;
      clrDone = 1'b0;
      setDone = 1'b0;
      startGo = 1'b0;
      n.sclkS1 = sclkIn;
      n.sclkS2 = q.sclkS1;
      n.sclkS3 = q.sclkS2;
      n.selS1  = selNIn;
      n.selS2  = q.selS1;
      n.mosiS1 = mosiIn;
      n.mosiS2 = q.mosiS1;
      n.misoS1 = misoIn;
      n.misoS2 = q.misoS1;

      // register bus: address and data may arrive in either order
      if (awvalid && awready) begin
         n.awHeld = 1'b1;
         n.awAddr = awaddr;
      end
      if (wvalid && wready) begin
         n.wHeld = 1'b1;
         n.wData = wdata;
         n.wStrb = wstrb;
      end
      writeFire = q.awHeld && q.wHeld && !q.bValid;
      wBitsSet  = q.wData & laneMask(q.wStrb);
      wEff      = wBitsSet;
      if (writeFire) begin
         n.awHeld = 1'b0;
         n.wHeld  = 1'b0;
         n.bValid = 1'b1;
         n.bResp  = RESP_OKAY;
         case (q.awAddr)
            OFF_CTRL: begin
               wEff = (q.wData & laneMask(q.wStrb)) | (rdCtrl() & ~laneMask(q.wStrb));
               n.serialClockPolarity  = wEff[BIT_POL];
               n.wordWidthSelect      = wEff[WID_LO+1:WID_LO];
               n.transactionCount     = wEff[CNT_LO+1:CNT_LO];
               n.transactionGapLength = wEff[GAP_LO+3:GAP_LO];
               n.doneIrqEnable        = wEff[BIT_IEN];
               n.slave                = wEff[BIT_SLAVE]; // [RULE1]
               n.perByteGapEnable     = wEff[BIT_BGAP];
               n.reorder              = wEff[BIT_REORD];
               clrDone = wBitsSet[BIT_DONE]; // [RULE4]
               startGo = wBitsSet[BIT_GO] && !wEff[BIT_SLAVE] && (q.state == ST_IDLE); // [RULE1]
            end
            OFF_TX:   n.txData = wEff | (q.txData & ~laneMask(q.wStrb));
            OFF_MASK: begin
               if (q.wStrb[0])
                  n.irqMask = q.wData[MASK_BIT];
            end
            OFF_RX:   n.bResp = RESP_OKAY;
            default:  n.bResp = RESP_SLVERR;
         endcase
      end
      if (q.bValid && bready)
         n.bValid = 1'b0;
      if (arvalid && arready) begin
         n.rValid = 1'b1;
         n.rData  = rdWord;
         n.rResp  = rdOk ? RESP_OKAY : RESP_SLVERR;
      end
      if (q.rValid && rready)
         n.rValid = 1'b0;

      // serial engine
      if (q.state == ST_IDLE || q.slave || tick)
         n.divCnt = '0;
      else
         n.divCnt = q.divCnt + 4'h1;
      case (q.state)
         ST_IDLE: begin
            n.sclk = q.serialClockPolarity;
            n.selN = 1'b1;
            if (startGo) begin
               n.state  = ST_SHIFT;
               n.selN   = 1'b0;
               n.shift  = loadWord;
               n.bitCnt = '0;
               n.txnCnt = '0;
               n.phase  = 1'b0;
            end else if (q.slave && !q.selS2) begin
               n.state  = ST_SHIFT;
               n.shift  = loadWord;
               n.bitCnt = '0;
            end
         end
         ST_SHIFT: begin
            if (q.slave) begin
               if (q.selS2)
                  n.state = ST_IDLE;
               else if (leadEdge)
                  n.rxBit = q.mosiS2;
               else if (trailEdge) begin
                  n.shift  = shNext;
                  n.bitCnt = bitNext;
                  if (bitNext == wBits) begin
                     n.rxData = (q.reorder && wordIs32) ? swapBytes(shNext) : (shNext & wMask);
                     setDone  = 1'b1;
                     n.shift  = loadWord;
                     n.bitCnt = '0;
                  end
               end
            end else if (tick) begin
               if (!q.phase) begin
                  n.sclk  = ~q.serialClockPolarity; // [RULE6]
                  n.rxBit = q.misoS2;
                  n.phase = 1'b1;
               end else begin
                  n.sclk   = q.serialClockPolarity; // [RULE6]
                  n.phase  = 1'b0;
                  n.shift  = shNext;
                  n.bitCnt = bitNext;
                  if (bitNext == wBits) begin
                     n.rxData = (q.reorder && wordIs32) ? swapBytes(shNext) : (shNext & wMask); // [RULE11]
                     if (q.txnCnt == q.transactionCount) begin
                        // count zero ends here, so only byte gaps ever apply
                        n.state = ST_IDLE; // [RULE8]
                        n.selN  = 1'b1;
                        setDone = 1'b1; // [RULE3]
                     end else begin
                        n.txnCnt = q.txnCnt + 2'h1;
                        n.shift  = loadWord;
                        n.bitCnt = '0;
                        n.state  = ST_GAP; // [RULE5]
                        n.gapCnt = gapHalves - CNT_W'(1); // [RULE12]
                     end
                  end else if (q.perByteGapEnable && wordIs32 && // [RULE9]
                               bitNext[2:0] == 3'h0) begin
                     n.state  = ST_GAP; // [RULE10]
                     n.gapCnt = gapHalves - CNT_W'(1);
                  end
               end
            end
         end
         ST_GAP: begin
            // gap ends one half period before the next leading edge
            if (tick) begin
               if (q.gapCnt == CNT_W'(1))
                  n.state = ST_SHIFT;
               else
                  n.gapCnt = q.gapCnt - CNT_W'(1);
            end
         end
         default: n.state = ST_IDLE;
      endcase
      if (startGo)
         n.doneIrqFlag = 1'b0; // [RULE3]
      // a completion in the clearing cycle is kept
      n.doneIrqFlag = (n.doneIrqFlag && !clrDone) || setDone; // [RULE3] [RULE4]
   end

   function automatic logic [DATA_W-1:0] rdCtrl();
      rdCtrl                      = '0;
      rdCtrl[BIT_POL]             = q.serialClockPolarity;
      rdCtrl[WID_LO+1:WID_LO]     = q.wordWidthSelect;
      rdCtrl[CNT_LO+1:CNT_LO]     = q.transactionCount;
      rdCtrl[GAP_LO+3:GAP_LO]     = q.transactionGapLength;
      rdCtrl[BIT_IEN]             = q.doneIrqEnable;
      rdCtrl[BIT_SLAVE]           = q.slave;
      rdCtrl[BIT_BGAP]            = q.perByteGapEnable;
      rdCtrl[BIT_REORD]           = q.reorder;
   endfunction : rdCtrl

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         q                      <= '0;
         q.transactionGapLength <= GAP_RST; // [RULE7]
         q.selN                 <= 1'b1;
         q.selS1                <= 1'b1;
         q.selS2                <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign awready = !q.awHeld && !q.bValid;
   assign wready  = !q.wHeld && !q.bValid;
   assign bvalid  = q.bValid;
   assign bresp   = q.bResp;
   assign arready = !q.rValid;
   assign rvalid  = q.rValid;
   assign rdata   = q.rData;
   assign rresp   = q.rResp;
   assign sclkOut = q.sclk;
   assign sclkOe  = !q.slave; // [RULE1]
   assign selNOut = q.selN;
   assign selNOe  = !q.slave;
   assign mosiOut = q.shift[SH_MSB];
   assign mosiOe  = !q.slave;
   assign misoOut = q.shift[SH_MSB];
   assign misoOe  = q.slave && !q.selS2;
   assign irq     = q.doneIrqFlag && q.doneIrqEnable && q.irqMask; // [RULE2]
endmodule : spct_ctrl

//--- spct_pkg.sv
// constants, register map and state type for the serial control block
// assumes a single 200 MHz core clock and a 32-bit AXI4-Lite register port
package spct_pkg;
   localparam int          ADDR_W      = 5;
   localparam int          DATA_W      = 32;
   localparam int          CNT_W       = 6;
   localparam logic [4:0]  OFF_CTRL    = 5'h00;
   localparam logic [4:0]  OFF_TX      = 5'h04;
   localparam logic [4:0]  OFF_RX      = 5'h08;
   localparam logic [4:0]  OFF_MASK    = 5'h0c;
   // control register field positions
   localparam int          BIT_GO      = 0;
   localparam int          BIT_POL     = 1;
   localparam int          WID_LO      = 2;
   localparam int          CNT_LO      = 4;
   localparam int          GAP_LO      = 12;
   localparam int          BIT_DONE    = 16;
   localparam int          BIT_IEN     = 17;
   localparam int          BIT_SLAVE   = 18;
   localparam int          BIT_BGAP    = 19;
   localparam int          BIT_REORD   = 20;
   localparam int          MASK_BIT    = 0;
   localparam int          SH_MSB      = 31;
   // word width select encodings
   localparam logic [1:0]  WIDTH_32    = 2'h0;
   localparam logic [1:0]  WIDTH_8     = 2'h1;
   localparam logic [1:0]  WIDTH_16    = 2'h2;
   localparam logic [1:0]  WIDTH_24    = 2'h3;
   localparam logic [3:0]  GAP_RST     = 4'h0;
   localparam logic [5:0]  GAP_EXTRA   = 6'h02;
   localparam logic [5:0]  BYTE_BITS   = 6'h08;
   localparam logic [5:0]  BITS_32     = 6'h20;
   localparam logic [5:0]  BITS_24     = 6'h18;
   localparam logic [5:0]  BITS_16     = 6'h10;
   // serial clock timing
   localparam int          CLK_NS      = 5;
   localparam int          SCLK_HALF_NS = 50;
   localparam int          HALF_CYC    = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0]  HALF_CYC_M1 = 4'(HALF_CYC - 1);
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} spct_state_t;
endpackage : spct_pkg

//--- spct_ctrl_monitor.sv
// checker for the serial control block, watching its top-level ports only
// assumes everything runs on core_clk with rst_n active low
`timescale 1ns/100ps
module spct_ctrl_monitor (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic sclkOut,
   input wire logic sclkOe,
   input wire logic selNOut,
   input wire logic selNOe,
   input wire logic mosiOut,
   input wire logic mosiOe,
   input wire logic misoOe,
   input wire logic irq
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write response not two cycles after the request");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read response not one cycle after the request");
   a_role_enables: assert property (mosiOe == selNOe && sclkOe == selNOe)
      else $error("pin enables disagree on the role");
   a_miso_slave: assert property (misoOe |-> !selNOe)
      else $error("data return driven in master role");
   a_clock_half: assert property ($changed(sclkOut) && !selNOut |=> $stable(sclkOut)[*8])
      else $error("serial clock half period too short");
   a_select_lead: assert property ($fell(selNOut) |-> $stable(sclkOut)[*8])
      else $error("serial clock moved too soon after select");
   a_data_trail: assert property (
      $changed(mosiOut) && !selNOut && !$past(selNOut) && selNOe |-> $changed(sclkOut))
      else $error("data changed away from a trailing edge");
   a_irq_rise: assert property (
      $rose(irq) |-> (selNOut && !$past(selNOut, 2)) or $past(bvalid) or ##[0:1] bvalid)
      else $error("interrupt rose without transfer end or register write");
   a_irq_clear: assert property ($fell(irq) |-> $past(bvalid) or ##[0:1] bvalid)
      else $error("interrupt fell without a register write");
endmodule : spct_ctrl_monitor

bind spct_ctrl spct_ctrl_monitor i_monitor (
   .core_clk(core_clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
   .arready(arready), .rvalid(rvalid), .sclkOut(sclkOut), .sclkOe(sclkOe),
   .selNOut(selNOut), .selNOe(selNOe), .mosiOut(mosiOut), .mosiOe(mosiOe),
   .misoOe(misoOe), .irq(irq));

//--- spct_far_end.sv
// behavioural serial slave standing on the far side of the controller
// assumes pins resolved by the bench and sampled on core_clk
`timescale 1ns/100ps
module spct_far_end (
   input  wire logic        core_clk,
   input  wire logic        clr,
   input  wire logic        pol,
   input  wire logic        sclk,
   input  wire logic        selN,
   input  wire logic        mosi,
   input  wire logic [31:0] txWord,
   output logic             miso,
   output logic [31:0]      rxWord,
   output logic [7:0]       bitCount,
   output logic [7:0]       longGap
);
   logic        sclkPrev = 1'b0;
   logic        selPrev  = 1'b1;
   logic        idlePat  = 1'b0;
   logic [31:0] txSh     = 32'h0;
   logic [7:0]  gapCnt   = 8'h0;
   // released line toggles so a stale bit never passes for data
   assign miso = selN ? idlePat : txSh[31];
   always @(posedge core_clk) begin
      sclkPrev <= sclk;
      selPrev  <= selN;
      idlePat  <= ~idlePat;
      if (clr) begin
         rxWord   <= 32'h0;
         bitCount <= 8'h0;
         longGap  <= 8'h0;
      end else if (selPrev && !selN) begin
         txSh   <= txWord;
         gapCnt <= 8'h0;
      end else if (!selN && sclk != sclkPrev) begin
         gapCnt <= 8'h0;
         if (gapCnt + 8'h1 > longGap) longGap <= gapCnt + 8'h1;
         if (sclk != pol) begin
            rxWord   <= {rxWord[30:0], mosi};
            bitCount <= bitCount + 8'h1;
         end else txSh <= {txSh[30:0], 1'b0};
      end else gapCnt <= gapCnt + 8'h1;
   end
endmodule : spct_far_end

//--- spi_control_timing_fields_test.sv
// self-checking bench for the serial control block and its far-end slave
// assumes register offsets and field positions from spct_pkg
`timescale 1ns/100ps
module spi_control_timing_fields_test;
   import spct_pkg::*;
   logic        core_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic [4:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, farTx, farRx;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic        awready, wready, bvalid, arready, rvalid, irq, farClr, farPol, farMiso;
   logic        sclkOut, sclkOe, selNOut, selNOe, mosiOut, mosiOe, misoOut, misoOe;
   logic        tbSclk, tbSelN, tbMosi, sclkPin, selPin, mosiPin, misoPin;
   logic [7:0]  farBits, farGap;
   int          failCount, checked;
   assign sclkPin = sclkOe ? sclkOut : tbSclk;
   assign selPin  = selNOe ? selNOut : tbSelN;
   assign mosiPin = mosiOe ? mosiOut : tbMosi;
   assign misoPin = misoOe ? misoOut : farMiso;
   spct_ctrl i_dut (.core_clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .sclkIn(sclkPin), .sclkOut, .sclkOe, .selNIn(selPin), .selNOut,
      .selNOe, .mosiIn(mosiPin), .mosiOut, .mosiOe, .misoIn(misoPin), .misoOut, .misoOe,
      .irq);
   spct_far_end i_far (.core_clk, .clr(farClr), .pol(farPol), .sclk(sclkPin), .selN(selPin),
      .mosi(mosiPin), .txWord(farTx), .miso(farMiso), .rxWord(farRx), .bitCount(farBits),
      .longGap(farGap));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         failCount++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, failCount);
      if (failCount == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   // readies sampled at the falling edge so the handshake edge is never raced
   task automatic axiWrite(input logic [4:0] a, input logic [31:0] d);
      int   n;
      logic awT, wT, bT;
      n = 0;
      bT = 1'b0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bT && n < 100) begin
         @(negedge core_clk);
         awT = awvalid && awready;
         wT = wvalid && wready;
         bT = bvalid && bready;
         @(posedge core_clk);
         if (awT) awvalid <= 1'b0;
         if (wT) wvalid <= 1'b0;
         if (bT) bready <= 1'b0;
         n++;
      end
      if (!bT) check("write response", 32'h1, 32'h0);
   endtask : axiWrite
   task automatic axiRead(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      int   n;
      logic arT, rT;
      n = 0;
      rT = 1'b0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rT && n < 100) begin
         @(negedge core_clk);
         arT = arvalid && arready;
         rT = rvalid && rready;
         d = rdata;
         r = rresp;
         @(posedge core_clk);
         if (arT) arvalid <= 1'b0;
         if (rT) rready <= 1'b0;
         n++;
      end
      if (!rT) check("read response", 32'h1, 32'h0);
   endtask : axiRead
   task automatic runXfer(input logic [31:0] cfg);
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      farClr <= 1'b1;
      axiWrite(OFF_CTRL, cfg);
      farClr <= 1'b0;
      axiWrite(OFF_CTRL, cfg | 32'h00000001);
      axiRead(OFF_CTRL, d, r);
      check("done while busy", 32'h0, 32'(d[BIT_DONE]));
      n = 0;
      do begin
         axiRead(OFF_CTRL, d, r);
         n++;
      end while (d[BIT_GO] !== 1'b0 && n < 500);
      check("done after transfer", 32'h1, 32'(d[BIT_DONE]));
   endtask : runXfer
   task automatic testReset();
      logic [31:0] d;
      logic [1:0]  r;
      axiRead(OFF_CTRL, d, r);
      check("gap field at reset", 32'h0, 32'(d[15:12]));
      check("role at reset", 32'h0, 32'(d[BIT_SLAVE]));
      axiRead(5'h10, d, r);
      check("unmapped response", 32'(RESP_SLVERR), 32'(r));
      check("unmapped data", 32'h0, d);
      axiWrite(OFF_MASK, 32'h00000001);
      axiRead(OFF_MASK, d, r);
      check("mask readback", 32'h1, 32'(d[MASK_BIT]));
      $display("test reset finished");
   endtask : testReset
   task automatic testWord();
      logic [31:0] d;
      logic [1:0]  r;
      farTx <= 32'h3c5a9617;
      axiWrite(OFF_TX, 32'ha5c30f96);
      runXfer(32'h00000000);
      check("sent word", 32'ha5c30f96, farRx);
      axiRead(OFF_RX, d, r);
      check("received word", 32'h3c5a9617, d);
      check("single word gap", 32'h0a, 32'(farGap));
      check("select idle", 32'h1, 32'(selNOut));
      $display("test word finished");
   endtask : testWord
   task automatic testIrq();
      logic [31:0] d;
      logic [1:0]  r;
      runXfer(32'h00020000);
      check("irq enabled", 32'h1, 32'(irq));
      axiWrite(OFF_CTRL, 32'h00020000);
      axiRead(OFF_CTRL, d, r);
      check("done after write zero", 32'h1, 32'(d[BIT_DONE]));
      axiWrite(OFF_CTRL, 32'h00030000);
      axiRead(OFF_CTRL, d, r);
      check("done after write one", 32'h0, 32'(d[BIT_DONE]));
      check("irq after clear", 32'h0, 32'(irq));
      runXfer(32'h00020000);
      axiWrite(OFF_MASK, 32'h00000000);
      check("irq masked", 32'h0, 32'(irq));
      axiWrite(OFF_MASK, 32'h00000001);
      check("irq unmasked", 32'h1, 32'(irq));
      runXfer(32'h00000000);
      check("irq disabled", 32'h0, 32'(irq));
      $display("test irq finished");
   endtask : testIrq
   task automatic testGaps();
      // one row per gap case
      logic [31:0] cfgs [5] = '{32'h00003010, 32'h00000012, 32'h00005000, 32'h00081000,
                                32'h00081004};
      logic [7:0]  gaps [5] = '{8'h64, 8'h28, 8'h0a, 8'h3c, 8'h0a};
      logic [7:0]  bits [5] = '{8'h40, 8'h40, 8'h20, 8'h20, 8'h08};
      foreach (cfgs[i]) begin
         farPol <= cfgs[i][BIT_POL];
         runXfer(cfgs[i]);
         check("longest clock gap", 32'(gaps[i]), 32'(farGap));
         check("bit count", 32'(bits[i]), 32'(farBits));
         check("idle clock level", 32'(cfgs[i][BIT_POL]), 32'(sclkOut));
      end
      farPol <= 1'b0;
      $display("test gaps finished");
   endtask : testGaps
   task automatic testReorder();
      logic [31:0] d;
      logic [1:0]  r;
      axiWrite(OFF_TX, 32'h11223344);
      runXfer(32'h00100000);
      check("reordered send", 32'h44332211, farRx);
      axiRead(OFF_RX, d, r);
      check("reordered receive", 32'h17965a3c, d);
      $display("test reorder finished");
   endtask : testReorder
   task automatic testSlave();
      logic [31:0] d;
      logic [1:0]  r;
      axiWrite(OFF_CTRL, 32'h00040001);
      repeat (4) @(posedge core_clk);
      axiRead(OFF_CTRL, d, r);
      check("go ignored in slave", 32'h1, 32'(d[BIT_DONE]));
      check("slave clock enable", 32'h0, 32'(sclkOe));
      check("slave select enable", 32'h0, 32'(selNOe));
      check("slave idle return", 32'h0, 32'(misoOe));
      tbSelN <= 1'b0;
      repeat (6) @(posedge core_clk);
      check("slave selected return", 32'h1, 32'(misoOe));
      tbSelN <= 1'b1;
      repeat (6) @(posedge core_clk);
      axiWrite(OFF_CTRL, 32'h00000000);
      $display("test slave finished");
   endtask : testSlave
   initial begin
      {rst_n, awvalid, wvalid, bready, arvalid, rready, farPol, tbSclk, tbMosi} = '0;
      {awaddr, araddr, wdata, farTx} = '0;
      {tbSelN, farClr} = 2'b11;
      wstrb = 4'hf;
      failCount = 0;
      checked = 0;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      testReset();
      testWord();
      testIrq();
      testGaps();
      testReorder();
      testSlave();
      finish_test();
   end
   initial begin
      repeat (60000) @(posedge core_clk);
      failCount++;
      finish_test();
   end
endmodule : spi_control_timing_fields_test
